/* inc/mu_cfg.svh */
// Purpose: constants of the message unit queue ports
// Assumes: included by its bare name after the package
// Notes:   definitions only
`ifndef MU_CFG_SVH
`define MU_CFG_SVH

// ----------------------------------------------------------------------
// queue geometry
// ----------------------------------------------------------------------
`define MU_PTR_W         16
`define MU_SIZE_W        17
`define MU_MIN_ENTRIES   17'h01000
`define MU_SIZE_SEL_MAX  3'h4
`define MU_PTR_ONE       17'h00001
`define MU_PTR_ZERO      16'h0000
`define MU_Q_IBP         2'h1
`define MU_Q_OBP         2'h2
`define MU_Q_OBF         2'h3

// ----------------------------------------------------------------------
// port selects, data and reset values
// ----------------------------------------------------------------------
`define MU_PORT_INBOUND  1'b0
`define MU_PORT_OUTBOUND 1'b1
`define MU_BE_NULL       4'hF
`define MU_ALL_ONES      32'hFFFFFFFF
`define MU_RST_PTR       16'h0000
`define MU_RST_IBP_HW    1'b0
`define MU_RST_OBF_HW    1'b0
`define MU_RST_OBP_HW    1'b1

`endif

/* inc/mu_pkg.sv */
// Purpose: types of the message unit queue ports
// Assumes: nothing
// Notes:   constants live in mu_cfg.svh
package mu_pkg;

  // ----------------------------------------------------------------------
  // memory sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_IBP_WR,
    ST_OBF_WR,
    ST_PF_RD
  } mu_state_type;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        wr;
    logic        port;
    logic [3:0]  be_n;
    logic [31:0] wdata;
  } mu_pci_req_type;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mu_mem_req_type;

endpackage

/* src/mu_queue_ports.sv */
// Purpose: hardware side of the inbound post, outbound post and outbound free queues
// Assumes: pci and core requests are synchronous to clock
// Notes:   one local memory port shared by posted writes and the prefetch
`include "mu_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module mu_queue_ports (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst_b,
  // pci target side
  input  wire mu_pkg::mu_pci_req_type pci_cmd,
  output logic                        pci_retry,
  output logic                        pci_done,
  output logic [31:0]                 pci_rdata,
  // local memory master
  output mu_pkg::mu_mem_req_type      mem_cmd,
  input  wire logic                   mem_ack,
  input  wire logic [31:0]            mem_rdata,
  // configuration
  input  wire logic [31:0]            queue_region_base,
  input  wire logic [2:0]             queue_size_sel,
  // core pointer writes
  input  wire logic                   core_ibp_tail_we,
  input  wire logic [15:0]            core_ibp_tail,
  input  wire logic                   core_obp_head_we,
  input  wire logic [15:0]            core_obp_head,
  input  wire logic                   core_obf_tail_we,
  input  wire logic [15:0]            core_obf_tail,
  // status clears and masks
  input  wire logic                   ibp_stat_clr,
  input  wire logic                   obf_full_stat_clr,
  input  wire logic                   ibp_mask,
  input  wire logic                   obf_full_mask,
  input  wire logic                   obp_mask,
  // pointers seen by the core
  output logic [15:0]                 ibp_head,
  output logic [15:0]                 ibp_tail,
  output logic [15:0]                 obp_head,
  output logic [15:0]                 obp_tail,
  output logic [15:0]                 obf_head,
  output logic [15:0]                 obf_tail,
  // queue status
  output logic                        ibp_empty,
  output logic                        ibp_full,
  output logic                        obp_empty,
  output logic                        obp_full,
  output logic                        obf_empty,
  output logic                        obf_full,
  output logic                        ibp_stat,
  output logic                        obf_full_stat,
  output logic                        obp_stat,
  output logic                        core_irq,
  output logic                        pci_irq
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  mu_pkg::mu_state_type   state_ff;
  mu_pkg::mu_mem_req_type mem_cmd_ff;
  logic [15:0]            ibp_head_ff;
  logic [15:0]            ibp_tail_ff;
  logic [15:0]            obp_head_ff;
  logic [15:0]            obp_tail_ff;
  logic [15:0]            obf_head_ff;
  logic [15:0]            obf_tail_ff;
  logic                   ibp_hw_ff;
  logic                   obp_hw_ff;
  logic                   obf_hw_ff;
  logic                   ibp_stat_ff;
  logic                   obf_full_stat_ff;
  logic [31:0]            prefetch_ff;
  logic                   pf_valid_ff;
  logic                   pf_pend_ff;

  // ----------------------------------------------------------------------
  // queue size and addressing
  // ----------------------------------------------------------------------
  logic [2:0]  size_sel;
  logic [16:0] q_size;
  logic [31:0] q_bytes;

  always_comb begin
    size_sel = (queue_size_sel > `MU_SIZE_SEL_MAX) ? `MU_SIZE_SEL_MAX : queue_size_sel;
    q_size   = `MU_MIN_ENTRIES << size_sel;
    q_bytes  = {13'h0000, q_size, 2'b00};
  end

  function automatic logic [15:0] ptr_inc(input logic [15:0] p, input logic [16:0] sz);
    logic [16:0] n;
    n = {1'b0, p} + `MU_PTR_ONE;
    ptr_inc = (n == sz) ? `MU_PTR_ZERO : n[15:0];
  endfunction

  // region k of the common layout: base + k * size in bytes
  function automatic logic [31:0] q_addr(input logic [1:0] q, input logic [15:0] p);
    logic [31:0] off;
    off = (q[0] ? q_bytes : 32'h00000000) + (q[1] ? {q_bytes[30:0], 1'b0} : 32'h00000000);
    q_addr = queue_region_base + off + {14'h0000, p, 2'b00};
  endfunction

  // ----------------------------------------------------------------------
  // empty and full decode
  // ----------------------------------------------------------------------
  logic ibp_eq;
  logic obp_eq;
  logic obf_eq;

  always_comb begin
    ibp_eq    = (ibp_head_ff == ibp_tail_ff);
    obp_eq    = (obp_head_ff == obp_tail_ff);
    obf_eq    = (obf_head_ff == obf_tail_ff);
    ibp_empty = ibp_eq & ~ibp_hw_ff;
    ibp_full  = ibp_eq & ibp_hw_ff;
    obf_empty = obf_eq & ~obf_hw_ff;
    obf_full  = obf_eq & obf_hw_ff;
    obp_empty = obp_eq & obp_hw_ff;
    obp_full  = obp_eq & ~obp_hw_ff;
  end

  // ----------------------------------------------------------------------
  // pci request decode and retry
  // ----------------------------------------------------------------------
  logic be_null;
  logic in_wr;
  logic in_rd;
  logic out_wr;
  logic out_rd;
  logic in_busy;
  logic out_busy;
  logic idle;

  always_comb begin
    idle     = (state_ff == mu_pkg::ST_IDLE);
    be_null  = (pci_cmd.be_n == `MU_BE_NULL);
    in_wr    = pci_cmd.valid & (pci_cmd.port == `MU_PORT_INBOUND) & pci_cmd.wr;
    in_rd    = pci_cmd.valid & (pci_cmd.port == `MU_PORT_INBOUND) & ~pci_cmd.wr;
    out_wr   = pci_cmd.valid & (pci_cmd.port == `MU_PORT_OUTBOUND) & pci_cmd.wr;
    out_rd   = pci_cmd.valid & (pci_cmd.port == `MU_PORT_OUTBOUND) & ~pci_cmd.wr;
    in_busy  = (state_ff == mu_pkg::ST_IBP_WR);
    out_busy = (state_ff == mu_pkg::ST_OBF_WR)
             | (state_ff == mu_pkg::ST_PF_RD) | pf_pend_ff;
    pci_retry = ((in_wr | in_rd) & in_busy)
              | (in_wr & ~be_null & (ibp_full | ~idle))
              | ((out_wr | out_rd) & out_busy)
              | (out_wr & ~be_null & (obf_full | ~idle));
    pci_done  = pci_cmd.valid & ~pci_retry;
  end

  logic take_ibp;
  logic take_obf;
  logic take_obp;

  always_comb begin
    take_ibp = in_wr & pci_done & ~be_null;
    take_obf = out_wr & pci_done & ~be_null;
    take_obp = out_rd & pci_done & ~be_null & pf_valid_ff;
  end

  // inbound free queue reads are not served here and answer all ones
  assign pci_rdata = (pci_cmd.port == `MU_PORT_OUTBOUND) ? prefetch_ff : `MU_ALL_ONES;

  // ----------------------------------------------------------------------
  // memory sequencer
  // ----------------------------------------------------------------------
  logic ibp_stored;
  logic obf_stored;
  logic pf_loaded;
  logic pf_launch;
  logic pf_empty_load;

  always_comb begin
    ibp_stored    = (state_ff == mu_pkg::ST_IBP_WR) & mem_ack;
    obf_stored    = (state_ff == mu_pkg::ST_OBF_WR) & mem_ack;
    pf_loaded     = (state_ff == mu_pkg::ST_PF_RD) & mem_ack;
    pf_launch     = idle & pf_pend_ff & ~take_ibp & ~obp_empty;
    pf_empty_load = idle & pf_pend_ff & ~take_ibp & obp_empty;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_ff         <= mu_pkg::ST_IDLE;
      mem_cmd_ff.req   <= 1'b0;
      mem_cmd_ff.we    <= 1'b0;
      mem_cmd_ff.addr  <= 32'h00000000;
      mem_cmd_ff.wdata <= 32'h00000000;
    end else begin
      case (state_ff)
        mu_pkg::ST_IDLE: begin
          if (take_ibp) begin
            state_ff         <= mu_pkg::ST_IBP_WR;
            mem_cmd_ff.req   <= 1'b1;
            mem_cmd_ff.we    <= 1'b1;
            mem_cmd_ff.addr  <= q_addr(`MU_Q_IBP, ibp_head_ff);
            mem_cmd_ff.wdata <= pci_cmd.wdata;
          end else if (take_obf) begin
            state_ff         <= mu_pkg::ST_OBF_WR;
            mem_cmd_ff.req   <= 1'b1;
            mem_cmd_ff.we    <= 1'b1;
            mem_cmd_ff.addr  <= q_addr(`MU_Q_OBF, obf_head_ff);
            mem_cmd_ff.wdata <= pci_cmd.wdata;
          end else if (pf_launch) begin
            state_ff         <= mu_pkg::ST_PF_RD;
            mem_cmd_ff.req   <= 1'b1;
            mem_cmd_ff.we    <= 1'b0;
            mem_cmd_ff.addr  <= q_addr(`MU_Q_OBP, obp_tail_ff);
          end
        end
        mu_pkg::ST_IBP_WR,
        mu_pkg::ST_OBF_WR,
        mu_pkg::ST_PF_RD: begin
          if (mem_ack) begin
            state_ff       <= mu_pkg::ST_IDLE;
            mem_cmd_ff.req <= 1'b0;
            mem_cmd_ff.we  <= 1'b0;
          end
        end
        default: begin
          state_ff       <= mu_pkg::ST_IDLE;
          mem_cmd_ff.req <= 1'b0;
        end
      endcase
    end
  end

  assign mem_cmd = mem_cmd_ff;

  // ----------------------------------------------------------------------
  // inbound post pointers
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ibp_head_ff <= `MU_RST_PTR;
      ibp_tail_ff <= `MU_RST_PTR;
      ibp_hw_ff   <= `MU_RST_IBP_HW;
    end else begin
      if (core_ibp_tail_we) begin
        ibp_tail_ff <= core_ibp_tail;
        ibp_hw_ff   <= 1'b0;
      end
      if (ibp_stored) begin
        ibp_head_ff <= ptr_inc(ibp_head_ff, q_size);
        ibp_hw_ff   <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // outbound free pointers
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      obf_head_ff <= `MU_RST_PTR;
      obf_tail_ff <= `MU_RST_PTR;
      obf_hw_ff   <= `MU_RST_OBF_HW;
    end else begin
      if (core_obf_tail_we) begin
        obf_tail_ff <= core_obf_tail;
        obf_hw_ff   <= 1'b0;
      end
      if (obf_stored) begin
        obf_head_ff <= ptr_inc(obf_head_ff, q_size);
        obf_hw_ff   <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // outbound post pointers
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      obp_head_ff <= `MU_RST_PTR;
      obp_tail_ff <= `MU_RST_PTR;
      obp_hw_ff   <= `MU_RST_OBP_HW;
    end else begin
      if (core_obp_head_we) begin
        obp_head_ff <= core_obp_head;
        obp_hw_ff   <= 1'b0;
      end
      if (take_obp) begin
        obp_tail_ff <= ptr_inc(obp_tail_ff, q_size);
        obp_hw_ff   <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // prefetch register
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prefetch_ff <= `MU_ALL_ONES;
      pf_valid_ff <= 1'b0;
      pf_pend_ff  <= 1'b0;
    end else begin
      if (pf_loaded) begin
        prefetch_ff <= mem_rdata;
        pf_valid_ff <= 1'b1;
      end else if (pf_empty_load) begin
        prefetch_ff <= `MU_ALL_ONES;
        pf_valid_ff <= 1'b0;
      end else if (take_obp) begin
        pf_valid_ff <= 1'b0;
      end
      // a new request wins over the launch that consumes the old one
      if (take_obp | (core_obp_head_we & ~pf_valid_ff)) begin
        pf_pend_ff <= 1'b1;
      end else if (pf_launch | pf_empty_load) begin
        pf_pend_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // status bits and interrupt lines
  // ----------------------------------------------------------------------
  logic obf_fills;

  always_comb begin
    obf_fills = obf_stored & (ptr_inc(obf_head_ff, q_size) == obf_tail_ff);
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ibp_stat_ff      <= 1'b0;
      obf_full_stat_ff <= 1'b0;
    end else begin
      // set wins over a clear in the same cycle
      if (ibp_stored) begin
        ibp_stat_ff <= 1'b1;
      end else if (ibp_stat_clr) begin
        ibp_stat_ff <= 1'b0;
      end
      if (obf_fills) begin
        obf_full_stat_ff <= 1'b1;
      end else if (obf_full_stat_clr) begin
        obf_full_stat_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    ibp_stat      = ibp_stat_ff;
    obf_full_stat = obf_full_stat_ff;
    obp_stat      = pf_valid_ff;
    core_irq      = (ibp_stat_ff & ~ibp_mask) | (obf_full_stat_ff & ~obf_full_mask);
    pci_irq       = pf_valid_ff & ~obp_mask;
  end

  // ----------------------------------------------------------------------
  // pointer outputs
  // ----------------------------------------------------------------------
  always_comb begin
    ibp_head = ibp_head_ff;
    ibp_tail = ibp_tail_ff;
    obp_head = obp_head_ff;
    obp_tail = obp_tail_ff;
    obf_head = obf_head_ff;
    obf_tail = obf_tail_ff;
  end

endmodule

`default_nettype wire

/* testbench/cmq_mem_model.sv */
// Purpose: local memory seen by the queue port block
// Assumes: one request at a time, held until acknowledged
// Notes:   answer delay is set by the bench through lat
`timescale 1ns/100ps
`default_nettype none
module cmq_mem_model (
  // clock
  input  wire logic                   clock,
  // memory port
  input  wire mu_pkg::mu_mem_req_type mem_cmd,
  output logic                        mem_ack,
  output logic [31:0]                 mem_rdata,
  // answer delay in cycles
  input  wire logic [3:0]             lat
);
  logic [31:0] mem [logic [31:0]];
  logic [3:0]  cnt;
  initial begin
    mem_ack   = 1'b0;
    mem_rdata = 32'h0;
    cnt       = 4'h0;
  end
  // read lines change every cycle so no stale word looks valid
  always @(posedge clock) begin
    mem_ack   <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_cmd.req && !mem_ack) begin
      if (cnt < lat) begin
        cnt <= cnt + 4'h1;
      end else begin
        cnt     <= 4'h0;
        mem_ack <= 1'b1;
        if (mem_cmd.we) begin
          mem[mem_cmd.addr] = mem_cmd.wdata;
        end else begin
          mem_rdata <= mem.exists(mem_cmd.addr) ? mem[mem_cmd.addr] : ~mem_cmd.addr;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/cmq_checker.sv */
// Purpose: concurrent checks on the queue port block
// Assumes: one clock domain, reset active low
// Notes:   bound to the block at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module cmq_checker (
  // clock and reset
  input wire logic                   clock,
  input wire logic                   rst_b,
  // pci and memory
  input wire mu_pkg::mu_pci_req_type pci_cmd,
  input wire logic                   pci_retry,
  input wire logic                   pci_done,
  input wire logic [31:0]            pci_rdata,
  input wire mu_pkg::mu_mem_req_type mem_cmd,
  input wire logic                   mem_ack,
  // configuration
  input wire logic [31:0]            queue_region_base,
  input wire logic [2:0]             queue_size_sel,
  // queue state
  input wire logic [15:0]            ibp_head,
  input wire logic [15:0]            obp_tail,
  input wire logic [15:0]            obf_head,
  input wire logic                   ibp_full,
  input wire logic                   obf_full,
  input wire logic                   ibp_stat,
  input wire logic                   obf_full_stat,
  input wire logic                   obp_stat
);
  logic [16:0] qn;
  logic [31:0] qb, off, base;
  logic        ib_st, ob_st, wr_ok, rd_ok;
  assign base  = queue_region_base;
  assign qn    = (queue_size_sel > 3'h4) ? 17'h10000 : (17'h01000 << queue_size_sel);
  assign qb    = {13'h0, qn, 2'h0};
  assign off   = mem_cmd.addr - base;
  assign ib_st = mem_cmd.req & mem_cmd.we & (off < {qb[30:0], 1'b0});
  assign ob_st = mem_cmd.req & mem_cmd.we & ~ib_st;
  assign wr_ok = pci_cmd.valid & pci_cmd.wr & (pci_cmd.be_n != 4'hF);
  assign rd_ok = pci_done & ~pci_cmd.wr;
  // next entry index with wrap at the queue size
  function automatic logic [15:0] wrap_inc(input logic [15:0] p);
    return (({1'b0, p} + 17'h1) == qn) ? 16'h0 : p + 16'h1;
  endfunction
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  AST_IBP_WR: assert property (pci_done & wr_ok & ~pci_cmd.port |=> ib_st &&
    mem_cmd.addr == base + qb + {14'h0, $past(ibp_head), 2'h0} &&
    mem_cmd.wdata == $past(pci_cmd.wdata)) else $error("inbound store misplaced");
  AST_OBF_WR: assert property (pci_done & wr_ok & pci_cmd.port |=> ob_st &&
    mem_cmd.addr == base + qb + {qb[30:0], 1'b0} + {14'h0, $past(obf_head), 2'h0})
    else $error("free store misplaced");
  AST_IBP_ADV: assert property (mem_ack & ib_st |=> ibp_stat &&
    ibp_head == wrap_inc($past(ibp_head))) else $error("inbound head not advanced");
  AST_OBF_ADV: assert property (mem_ack & ob_st |=>
    obf_head == wrap_inc($past(obf_head))) else $error("free head not advanced");
  AST_IN_BUSY: assert property (pci_cmd.valid & ~pci_cmd.port & ib_st |-> pci_retry)
    else $error("inbound access taken during store");
  AST_OUT_BUSY: assert property (pci_cmd.valid & pci_cmd.port & mem_cmd.req & ~ib_st
    |-> pci_retry) else $error("outbound access taken while busy");
  AST_FULL: assert property (wr_ok & (pci_cmd.port ? obf_full : ibp_full) |-> pci_retry)
    else $error("write taken into full queue");
  AST_PF_ADDR: assert property (mem_cmd.req & ~mem_cmd.we |->
    mem_cmd.addr == base + {qb[30:0], 1'b0} + {14'h0, obp_tail, 2'h0})
    else $error("prefetch address wrong");
  AST_EMPTY_RD: assert property (rd_ok & ~obp_stat |-> pci_rdata == 32'hFFFFFFFF)
    else $error("empty read not all ones");
  AST_CONSUME: assert property (rd_ok & pci_cmd.port & obp_stat & (pci_cmd.be_n != 4'hF)
    |=> !obp_stat && obp_tail == wrap_inc($past(obp_tail))) else $error("tail not advanced");
  AST_NULL: assert property (pci_done & (pci_cmd.be_n == 4'hF) |=>
    $stable(ibp_head) && $stable(obp_tail)) else $error("null access moved a pointer");
  AST_STAT_HOLD: assert property (!ibp_stat & !(mem_ack & ib_st) |=> !ibp_stat)
    else $error("inbound status raised without posting");
  AST_FULL_STAT: assert property ($rose(obf_full) |-> ##[0:1] obf_full_stat)
    else $error("free full status not set");
  COV_STORE: cover property (mem_ack & ib_st);
  COV_FULL: cover property (wr_ok & ibp_full & pci_retry);
  COV_READ: cover property (rd_ok & pci_cmd.port & obp_stat);
endmodule
bind mu_queue_ports cmq_checker i_cmq_checker (.clock, .rst_b, .pci_cmd, .pci_retry,
  .pci_done, .pci_rdata, .mem_cmd, .mem_ack, .queue_region_base, .queue_size_sel, .ibp_head,
  .obp_tail, .obf_head, .ibp_full, .obf_full, .ibp_stat, .obf_full_stat, .obp_stat);
`default_nettype wire

/* testbench/circular_message_queue_ports_bench.sv */
// Purpose: self-checking bench of the queue port block
// Assumes: smallest queue size, memory answered by cmq_mem_model
// Notes:   the bench acts as pci agent and as core
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module circular_message_queue_ports_bench;
  localparam logic [31:0] BASE = 32'h00100000;
  localparam logic [31:0] QB   = 32'h00004000;
  logic clock, rst_b, pci_retry, pci_done, mem_ack, rt, dn;
  mu_pkg::mu_pci_req_type pci_cmd;
  mu_pkg::mu_mem_req_type mem_cmd;
  logic [31:0] pci_rdata, mem_rdata, queue_region_base, rd;
  logic [2:0]  queue_size_sel;
  logic [3:0]  lat;
  logic [15:0] core_ibp_tail, core_obp_head, core_obf_tail;
  logic [15:0] ibp_head, ibp_tail, obp_head, obp_tail, obf_head, obf_tail;
  logic core_ibp_tail_we, core_obp_head_we, core_obf_tail_we, ibp_stat_clr, obf_full_stat_clr;
  logic ibp_mask, obf_full_mask, obp_mask, ibp_stat, obf_full_stat, obp_stat, core_irq, pci_irq;
  logic ibp_empty, ibp_full, obp_empty, obp_full, obf_empty, obf_full;
  int   errors, n_tests;
  mu_queue_ports i_mu_queue_ports (.clock, .rst_b, .pci_cmd, .pci_retry, .pci_done, .pci_rdata,
    .mem_cmd, .mem_ack, .mem_rdata, .queue_region_base, .queue_size_sel, .core_ibp_tail_we,
    .core_ibp_tail, .core_obp_head_we, .core_obp_head, .core_obf_tail_we, .core_obf_tail,
    .ibp_stat_clr, .obf_full_stat_clr, .ibp_mask, .obf_full_mask, .obp_mask, .ibp_head,
    .ibp_tail, .obp_head, .obp_tail, .obf_head, .obf_tail, .ibp_empty, .ibp_full, .obp_empty,
    .obp_full, .obf_empty, .obf_full, .ibp_stat, .obf_full_stat, .obp_stat, .core_irq, .pci_irq);
  cmq_mem_model i_cmq_mem_model (.clock, .mem_cmd, .mem_ack, .mem_rdata, .lat);
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one access cycle; answer sampled just before the taking edge
  task automatic pci(input logic w, input logic p, input logic [3:0] be, input logic [31:0] wd);
    @(posedge clock);
    #1;
    pci_cmd <= '{1'b1, w, p, be, wd};
    #6;
    rt = pci_retry;
    dn = pci_done;
    rd = pci_rdata;
    @(posedge clock);
    #1;
    pci_cmd.valid <= 1'b0;
  endtask
  task automatic pci_go(input logic w, input logic p, input logic [3:0] be, input logic [31:0] wd);
    for (int i = 0; i < 40; i++) begin
      pci(w, p, be, wd);
      if (dn === 1'b1) return;
    end
    errors++;
    complete_run();
  endtask
  // memory quiet for four cycles: stores and prefetches are over
  task automatic wait_idle();
    int n;
    n = 0;
    for (int i = 0; i < 60; i++) begin
      @(posedge clock);
      #1;
      n = (mem_cmd.req === 1'b0) ? n + 1 : 0;
      if (n == 4) return;
    end
    errors++;
    complete_run();
  endtask
  // k: status clears, then ibp tail, obp head, obf tail writes
  task automatic core_op(input logic [4:0] k, input logic [15:0] v);
    @(posedge clock);
    #1;
    {core_ibp_tail, core_obp_head, core_obf_tail} <= {3{v}};
    {ibp_stat_clr, obf_full_stat_clr, core_ibp_tail_we, core_obp_head_we, core_obf_tail_we} <= k;
    @(posedge clock);
    #1;
    {ibp_stat_clr, obf_full_stat_clr, core_ibp_tail_we, core_obp_head_we, core_obf_tail_we} <= 5'h0;
  endtask
  task automatic fill(input logic p, input int n);
    for (int i = 0; i < n; i++) pci_go(1'b1, p, 4'h0, {16'hA000, 16'(i)});
    wait_idle();
  endtask
  initial begin
    pci_cmd = '0;
    {core_ibp_tail, core_obp_head, core_obf_tail} = '0;
    {ibp_stat_clr, obf_full_stat_clr, core_ibp_tail_we, core_obp_head_we, core_obf_tail_we} = '0;
    {ibp_mask, obf_full_mask, obp_mask} = 3'h0;
    queue_region_base = BASE;
    queue_size_sel = 3'h0;
    lat = 4'h3;
    errors = 0;
    n_tests = 0;
    rst_b = 1'b0;
    repeat (5) @(posedge clock);
    #1;
    rst_b = 1'b1;
    `CHK("reset state", 38'h3800000000, {ibp_empty, obp_empty, obf_empty, ibp_full, obp_full, obf_full, ibp_stat, obf_full_stat, obp_stat, ibp_head, obp_tail[12:0]})
    pci_go(1'b1, 1'b0, 4'h0, 32'hCAFE0001);
    pci(1'b1, 1'b0, 4'h0, 32'h0);
    `CHK("inbound busy", 1'b1, rt)
    wait_idle();
    `CHK("inbound word", 32'hCAFE0001, i_cmq_mem_model.mem[BASE + QB])
    `CHK("inbound head", 18'h30001, {ibp_stat, core_irq, ibp_head})
    ibp_mask = 1'b1;
    #1;
    `CHK("inbound masked", 1'b0, core_irq)
    ibp_mask = 1'b0;
    core_op(5'h10, 16'h0);
    wait_idle();
    `CHK("no re-raise", 2'h0, {ibp_stat, ibp_empty})
    core_op(5'h04, 16'h1);
    `CHK("inbound empty", 1'b1, ibp_empty)
    pci_go(1'b1, 1'b0, 4'hF, 32'h0);
    wait_idle();
    `CHK("null write", 17'h00001, {ibp_stat, ibp_head})
    pci_go(1'b0, 1'b1, 4'h0, 32'h0);
    `CHK("empty read", 48'hFFFFFFFF0000, {rd, obp_tail})
    for (int i = 0; i < 3; i++) i_cmq_mem_model.mem[BASE + 2 * QB + 32'(4 * i)] = {16'hBEEF, 16'(i)};
    core_op(5'h02, 16'h2);
    pci(1'b0, 1'b1, 4'h0, 32'h0);
    `CHK("prefetch busy", 1'b1, rt)
    wait_idle();
    `CHK("prefetch irq", 2'h3, {obp_stat, pci_irq})
    obp_mask = 1'b1;
    #1;
    `CHK("pci irq masked", 1'b0, pci_irq)
    obp_mask = 1'b0;
    for (int i = 0; i < 2; i++) begin
      pci_go(1'b0, 1'b1, 4'h0, 32'h0);
      `CHK("outbound word", {16'hBEEF, 16'(i)}, rd)
      wait_idle();
      `CHK("outbound tail", 16'(i + 1), obp_tail)
    end
    `CHK("outbound empty", 2'h2, {obp_empty, obp_stat})
    core_op(5'h02, 16'h2);
    wait_idle();
    `CHK("outbound full", 1'b1, obp_full)
    pci_go(1'b0, 1'b1, 4'h0, 32'h0);
    `CHK("full read", 32'hBEEF0002, rd)
    lat = 4'h1;
    pci_go(1'b1, 1'b1, 4'h0, 32'hF00D0000);
    pci(1'b1, 1'b1, 4'h0, 32'h0);
    `CHK("free busy", 1'b1, rt)
    wait_idle();
    `CHK("free word", 32'hF00D0000, i_cmq_mem_model.mem[BASE + 3 * QB])
    `CHK("free head", 16'h1, obf_head)
    fill(1'b0, 4096);
    `CHK("inbound full", 17'h10001, {ibp_full, ibp_head})
    pci(1'b1, 1'b0, 4'h0, 32'h0);
    `CHK("inbound full retry", 1'b1, rt)
    core_op(5'h04, 16'h2);
    pci_go(1'b1, 1'b0, 4'h0, 32'h12345678);
    wait_idle();
    `CHK("slot reused", 32'h12345678, i_cmq_mem_model.mem[BASE + QB + 32'h4])
    ibp_mask = 1'b1;
    fill(1'b1, 4095);
    `CHK("free full", 19'h70000, {obf_full, obf_full_stat, core_irq, obf_head})
    pci(1'b1, 1'b1, 4'h0, 32'h0);
    `CHK("free full retry", 1'b1, rt)
    core_op(5'h01, 16'h5);
    `CHK("free stat sticky", 2'h1, {obf_full, obf_full_stat})
    `CHK("core pointers", 48'h000200020005, {ibp_tail, obp_head, obf_tail})
    core_op(5'h08, 16'h0);
    `CHK("free stat cleared", 2'h0, {obf_full_stat, core_irq})
    complete_run();
  end
endmodule
`default_nettype wire
